// File: scg_map.svh
// Offsets, field positions, reset values and limits of the sleep clock gating block.
// Assumes it is included by its bare name wherever a constant is needed.
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH

`define SCG_OFS_RUN_CFG    12'h060
`define SCG_OFS_RUN_GATE   12'h100
`define SCG_OFS_SLEEP_GATE 12'h110
`define SCG_OFS_IRQ_STAT   12'h150
`define SCG_OFS_IRQ_MASK   12'h154

`define SCG_BIT_PWM        20
`define SCG_BIT_ADC        16
`define SCG_BIT_SPD_HI     9
`define SCG_BIT_SPD_LO     8
`define SCG_BIT_FIXED_ONE  6
`define SCG_BIT_WDT        3
`define SCG_BIT_ACG        0

`define SCG_BIT_EV_FAULT   0
`define SCG_BIT_EV_SLEEP   1
`define SCG_BIT_EV_WAKE    2

`define SCG_GATE_RESET     32'h00000040
`define SCG_SPD_MAX        2'h2
`define SCG_EV_RESET       3'h0

`endif

// File: scg_pkg.sv
// Types of the sleep clock gating block.
// Assumes scg_map.svh supplies the numeric constants.
package scg_pkg;

	typedef enum logic [1:0] {
		SCG_MODE_RUN   = 2'h0,
		SCG_MODE_SLEEP = 2'h1
	} scg_mode_type;

	typedef enum logic [1:0] {
		SCG_UNIT_PWM = 2'h0,
		SCG_UNIT_ADC = 2'h1,
		SCG_UNIT_WDT = 2'h2
	} scg_unit_type;

	typedef struct packed {
		logic       pwm;
		logic       adc;
		logic       wdt;
		logic [1:0] speed;
	} scg_gate_type;

	typedef struct packed {
		scg_mode_type mode;
		logic         auto_clock_gating_enable;
		scg_gate_type run_gate;
		scg_gate_type sleep_gate;
		scg_gate_type en;
		logic [2:0]   stat;
		logic [2:0]   mask;
		logic         irq;
		logic [31:0]  rdata;
		logic         fault;
		logic         done;
	} scg_state_type;

endpackage : scg_pkg

// File: scg_top.sv
// Sleep clock gating control: run and sleep gating registers, the
// effective peripheral clock enables, bus fault on gated access, interrupts.
// Assumes the core drives the register and peripheral ports on this clock.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "scg_map.svh"

module scg_top (
	input  wire logic               clock,
	input  wire logic               srst,
	input  wire logic               ce,
	input  wire logic [11:0]        addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	output logic      [31:0]        rdata,
	input  wire logic               sleep_req,
	input  wire logic               periph_req,
	input  wire scg_pkg::scg_unit_type periph_sel,
	output logic                    periph_fault,
	output logic                    periph_done,
	output logic                    pwm_clk_en,
	output logic                    adc_clk_en,
	output logic                    wdt_clk_en,
	output logic      [1:0]         adc_sample_speed_select,
	output logic                    irq
);

	scg_pkg::scg_state_type state;
	scg_pkg::scg_state_type next_state;

	function automatic scg_pkg::scg_gate_type unpack_gate(input logic [31:0] d);
		scg_pkg::scg_gate_type g;
		g.pwm = d[`SCG_BIT_PWM];
		g.adc = d[`SCG_BIT_ADC];
		g.wdt = d[`SCG_BIT_WDT];
		g.speed = d[`SCG_BIT_SPD_HI:`SCG_BIT_SPD_LO];
		if (g.speed > `SCG_SPD_MAX) begin
			g.speed = `SCG_SPD_MAX;
		end
		return g;
	endfunction : unpack_gate

	function automatic logic [31:0] pack_gate(input scg_pkg::scg_gate_type g);
		logic [31:0] d;
		d = `SCG_GATE_RESET;
		d[`SCG_BIT_PWM] = g.pwm;
		d[`SCG_BIT_ADC] = g.adc;
		d[`SCG_BIT_WDT] = g.wdt;
		d[`SCG_BIT_SPD_HI:`SCG_BIT_SPD_LO] = g.speed;
		return d;
	endfunction : pack_gate

	function automatic logic unit_on(input scg_pkg::scg_gate_type g,
		input scg_pkg::scg_unit_type u);
		logic on;
		on = 1'b0;
		case (u)
			scg_pkg::SCG_UNIT_PWM: on = g.pwm;
			scg_pkg::SCG_UNIT_ADC: on = g.adc;
			scg_pkg::SCG_UNIT_WDT: on = g.wdt;
			default: on = 1'b0;
		endcase
		return on;
	endfunction : unit_on

	logic [2:0] ev;
	logic [2:0] clr;

	always_comb begin
		next_state = state;
		ev = 3'h0;
		clr = 3'h0;
		next_state.fault = 1'b0;
		next_state.done = 1'b0;
		next_state.rdata = 32'h0;
		// Register writes.
		if (wr) begin
			if (addr == `SCG_OFS_RUN_GATE) begin
				next_state.run_gate = unpack_gate(wdata);
			end else if (addr == `SCG_OFS_SLEEP_GATE) begin
				next_state.sleep_gate = unpack_gate(wdata);
			end else if (addr == `SCG_OFS_RUN_CFG) begin
				next_state.auto_clock_gating_enable = wdata[`SCG_BIT_ACG];
			end else if (addr == `SCG_OFS_IRQ_STAT) begin
				clr = wdata[2:0];
			end else if (addr == `SCG_OFS_IRQ_MASK) begin
				next_state.mask = wdata[2:0];
			end
		end
		// Register reads; unmapped addresses read zero.
		if (rd) begin
			if (addr == `SCG_OFS_RUN_GATE) begin
				next_state.rdata = pack_gate(state.run_gate);
			end else if (addr == `SCG_OFS_SLEEP_GATE) begin
				next_state.rdata = pack_gate(state.sleep_gate);
			end else if (addr == `SCG_OFS_RUN_CFG) begin
				next_state.rdata = {31'h0, state.auto_clock_gating_enable};
			end else if (addr == `SCG_OFS_IRQ_STAT) begin
				next_state.rdata = {29'h0, state.stat};
			end else if (addr == `SCG_OFS_IRQ_MASK) begin
				next_state.rdata = {29'h0, state.mask};
			end
		end
		// Power mode follows the core's sleep request.
		case (state.mode)
			scg_pkg::SCG_MODE_RUN: begin
				if (sleep_req) begin
					next_state.mode = scg_pkg::SCG_MODE_SLEEP;
					ev[`SCG_BIT_EV_SLEEP] = 1'b1;
				end
			end
			scg_pkg::SCG_MODE_SLEEP: begin
				if (!sleep_req) begin
					next_state.mode = scg_pkg::SCG_MODE_RUN;
					ev[`SCG_BIT_EV_WAKE] = 1'b1;
				end
			end
			default: next_state.mode = scg_pkg::SCG_MODE_RUN;
		endcase
		// Effective enables from the sleep register in sleep mode with auto gating on, else from the run register.
		if (next_state.mode == scg_pkg::SCG_MODE_SLEEP && next_state.auto_clock_gating_enable) begin
			next_state.en = next_state.sleep_gate;
		end else begin
			next_state.en = next_state.run_gate;
		end
		// Peripheral accesses complete only on a clocked unit.
		if (periph_req) begin
			if (unit_on(state.en, periph_sel)) begin
				next_state.done = 1'b1;
			end else begin
				next_state.fault = 1'b1;
				ev[`SCG_BIT_EV_FAULT] = 1'b1;
			end
		end
		// A new event wins over a clear in the same cycle.
		next_state.stat = (state.stat & ~clr) | ev;
		next_state.irq = |(next_state.stat & next_state.mask);
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state.mode <= scg_pkg::SCG_MODE_RUN;
			state.auto_clock_gating_enable <= 1'b0;
			state.run_gate <= '0;
			state.sleep_gate <= '0;
			state.en <= '0;
			state.stat <= `SCG_EV_RESET;
			state.mask <= `SCG_EV_RESET;
			state.irq <= 1'b0;
			state.rdata <= 32'h0;
			state.fault <= 1'b0;
			state.done <= 1'b0;
		end else if (ce) begin
			state <= next_state;
		end
	end

	assign rdata = state.rdata;
	assign periph_fault = state.fault;
	assign periph_done = state.done;
	assign pwm_clk_en = state.en.pwm;
	assign adc_clk_en = state.en.adc;
	assign wdt_clk_en = state.en.wdt;
	assign adc_sample_speed_select = state.en.speed;
	assign irq = state.irq;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	property p_sleep_select;
		(state.mode == scg_pkg::SCG_MODE_SLEEP && state.auto_clock_gating_enable) |->
			({pwm_clk_en, adc_clk_en, wdt_clk_en} ==
			 {state.sleep_gate.pwm, state.sleep_gate.adc, state.sleep_gate.wdt});
	endproperty
	a_sleep_select: assert property (p_sleep_select) else $error("sleep enables wrong");

	property p_run_select;
		(ce && !sleep_req) |=> (state.en == state.run_gate);
	endproperty
	a_run_select: assert property (p_run_select) else $error("run enables not restored");

	property p_fault;
		(ce && periph_req && !unit_on(state.en, periph_sel)) |=>
			(periph_fault && !periph_done);
	endproperty
	a_fault: assert property (p_fault) else $error("gated access did not fault");

	property p_done;
		(ce && periph_req && unit_on(state.en, periph_sel)) |=>
			(periph_done && !periph_fault);
	endproperty
	a_done: assert property (p_done) else $error("clocked access faulted");

	property p_gate_off;
		(ce && sleep_req && state.auto_clock_gating_enable && !wr && !state.sleep_gate.pwm) |=> !pwm_clk_en;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("pwm clock not stopped");

	property p_reset;
		$past(srst) |-> (!pwm_clk_en && !adc_clk_en && !wdt_clk_en && state.sleep_gate == '0);
	endproperty
	a_reset: assert property (p_reset) else $error("gates not zero after reset");

	property p_wdt_bit;
		(ce && wr && addr == `SCG_OFS_SLEEP_GATE) |=>
			(state.sleep_gate.wdt == $past(wdata[`SCG_BIT_WDT]));
	endproperty
	a_wdt_bit: assert property (p_wdt_bit) else $error("watchdog bit not stored");

	property p_speed;
		(ce && wr && addr == `SCG_OFS_SLEEP_GATE && wdata[9:8] != 2'h3) |=>
			(state.sleep_gate.speed == $past(wdata[9:8]));
	endproperty
	a_speed: assert property (p_speed) else $error("speed field not stored");

	property p_speed_max;
		(ce && wr && addr == `SCG_OFS_SLEEP_GATE && wdata[9:8] == 2'h3) |=>
			(state.sleep_gate.speed == `SCG_SPD_MAX);
	endproperty
	a_speed_max: assert property (p_speed_max) else $error("speed above maximum");

	property p_read_value;
		(ce && rd && addr == `SCG_OFS_SLEEP_GATE) |=>
			(rdata[`SCG_BIT_FIXED_ONE] && (rdata & 32'hffeefcb7) == 32'h0);
	endproperty
	a_read_value: assert property (p_read_value) else $error("sleep gate read wrong");

	property p_fault_status;
		(ce && periph_req && !unit_on(state.en, periph_sel)) |=> state.stat[`SCG_BIT_EV_FAULT];
	endproperty
	a_fault_status: assert property (p_fault_status) else $error("fault status not set");

	property p_fault_irq;
		(ce && periph_req && !wr && state.mask[`SCG_BIT_EV_FAULT] &&
			!unit_on(state.en, periph_sel)) |=> irq;
	endproperty
	a_fault_irq: assert property (p_fault_irq) else $error("fault raised no interrupt");

	property p_speed_range;
		adc_sample_speed_select != 2'h3;
	endproperty
	a_speed_range: assert property (p_speed_range) else $error("speed code out of range");

	property p_run_clamp;
		(ce && wr && addr == `SCG_OFS_RUN_GATE && wdata[9:8] == 2'h3) |=>
			(state.run_gate.speed == `SCG_SPD_MAX);
	endproperty
	a_run_clamp: assert property (p_run_clamp) else $error("run speed above maximum");

	property p_pwm_bit;
		(ce && wr && addr == `SCG_OFS_SLEEP_GATE) |=>
			(state.sleep_gate.pwm == $past(wdata[`SCG_BIT_PWM]));
	endproperty
	a_pwm_bit: assert property (p_pwm_bit) else $error("pwm bit not stored");

	property p_adc_bit;
		(ce && wr && addr == `SCG_OFS_SLEEP_GATE) |=>
			(state.sleep_gate.adc == $past(wdata[`SCG_BIT_ADC]));
	endproperty
	a_adc_bit: assert property (p_adc_bit) else $error("adc bit not stored");

	property p_acg_off;
		(ce && sleep_req && !state.auto_clock_gating_enable && !wr) |=> (state.en == state.run_gate);
	endproperty
	a_acg_off: assert property (p_acg_off) else $error("sleep gating without auto gating");

	property p_gate_on;
		(ce && sleep_req && state.auto_clock_gating_enable && !wr && state.sleep_gate.adc) |=> adc_clk_en;
	endproperty
	a_gate_on: assert property (p_gate_on) else $error("adc clock not running");

	property p_wdt_sleep;
		(ce && sleep_req && state.auto_clock_gating_enable && !wr) |=> (wdt_clk_en == state.sleep_gate.wdt);
	endproperty
	a_wdt_sleep: assert property (p_wdt_sleep) else $error("watchdog enable wrong in sleep");

	property p_wake;
		(ce && state.mode == scg_pkg::SCG_MODE_SLEEP && !sleep_req) |=>
			(state.mode == scg_pkg::SCG_MODE_RUN && state.stat[`SCG_BIT_EV_WAKE]);
	endproperty
	a_wake: assert property (p_wake) else $error("wake not taken");

	c_sleep_fault: cover property (state.mode == scg_pkg::SCG_MODE_SLEEP && periph_fault);
	c_wake: cover property (state.mode == scg_pkg::SCG_MODE_SLEEP ##1
		state.mode == scg_pkg::SCG_MODE_RUN);
	c_irq: cover property (irq);
	c_clamp: cover property (adc_sample_speed_select == `SCG_SPD_MAX);
	c_sleep_read: cover property (rd && addr == `SCG_OFS_SLEEP_GATE ##1 rdata != 32'h0);

endmodule : scg_top

// File: scg_core_model.sv
// Behavioural model of the core: sleep level and peripheral accesses.
// Assumes the bench calls its tasks and that the block answers one cycle later.
`timescale 1ns/1ps
module scg_core_model (
	output logic                  sleep_req,
	output logic                  periph_req,
	output scg_pkg::scg_unit_type periph_sel,
	input  wire logic             clock,
	input  wire logic             periph_fault,
	input  wire logic             periph_done
);
	initial begin
		sleep_req  = 1'b0;
		periph_req = 1'b0;
		periph_sel = scg_pkg::SCG_UNIT_PWM;
	end

	// Issues one access and returns the answer of the following cycle.
	task access(input scg_pkg::scg_unit_type s, output logic f, output logic d);
		@(posedge clock);
		periph_req <= 1'b1;
		periph_sel <= s;
		@(posedge clock);
		periph_req <= 1'b0;
		#1;
		f = periph_fault;
		d = periph_done;
	endtask : access

	// Changes the sleep level and lets the enables settle.
	task set_sleep(input logic v);
		@(posedge clock);
		sleep_req <= v;
		repeat (3) @(posedge clock);
		#1;
	endtask : set_sleep
endmodule : scg_core_model

// File: scg_top_tb.sv
// Self-checking bench of the sleep clock gating block.
// Assumes scg_top and scg_core_model; register access is one-cycle strobes.
`timescale 1ns/1ps
module scg_top_tb;
	logic                  clock;
	logic                  srst;
	logic                  ce;
	logic [11:0]           addr;
	logic [31:0]           wdata;
	logic                  wr;
	logic                  rd;
	logic [31:0]           rdata;
	logic                  sleep_req;
	logic                  periph_req;
	scg_pkg::scg_unit_type periph_sel;
	logic                  periph_fault;
	logic                  periph_done;
	logic                  pwm_clk_en;
	logic                  adc_clk_en;
	logic                  wdt_clk_en;
	logic [1:0]            spd;
	logic                  irq;
	logic                  f;
	logic                  d;
	int                    fail_count;
	int                    n_tests;
	int                    cycles;

	scg_top DUT (.clock(clock), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .sleep_req(sleep_req), .periph_req(periph_req),
		.periph_sel(periph_sel), .periph_fault(periph_fault), .periph_done(periph_done),
		.pwm_clk_en(pwm_clk_en), .adc_clk_en(adc_clk_en), .wdt_clk_en(wdt_clk_en),
		.adc_sample_speed_select(spd), .irq(irq));
	scg_core_model core (.clock(clock), .sleep_req(sleep_req), .periph_req(periph_req),
		.periph_sel(periph_sel), .periph_fault(periph_fault), .periph_done(periph_done));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task wr_reg(input logic [11:0] a, input logic [31:0] v);
		@(posedge clock);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : wr_reg

	task rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
		@(posedge clock);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		chk(name, exp, rdata);
	endtask : rd_chk

	task en_chk(input logic [4:0] exp);
		#1;
		chk("enables", {27'h0, exp}, {27'h0, pwm_clk_en, adc_clk_en, wdt_clk_en, spd});
	endtask : en_chk

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			tally_and_finish;
		end
	end

	initial begin
		srst  = 1'b1;
		ce    = 1'b1;
		addr  = 12'h000;
		wdata = 32'h0;
		wr    = 1'b0;
		rd    = 1'b0;
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		en_chk(5'h00);
		rd_chk("sleep gate reset", 12'h110, 32'h00000040);
		wr_reg(12'h154, 32'h00000001);
		core.access(scg_pkg::SCG_UNIT_WDT, f, d);
		chk("wdt fault", 32'h1, {31'h0, f});
		chk("irq set", 32'h1, {31'h0, irq});
		rd_chk("status", 12'h150, 32'h00000001);
		wr_reg(12'h150, 32'h00000001);
		chk("irq clear", 32'h0, {31'h0, irq});
		wr_reg(12'h100, 32'h00110348);
		en_chk(5'h1e);
		core.access(scg_pkg::SCG_UNIT_PWM, f, d);
		chk("pwm done", 32'h1, {31'h0, d});
		wr_reg(12'h110, 32'hffeefcb7);
		rd_chk("sleep gate ignores", 12'h110, 32'h00000040);
		wr_reg(12'h110, 32'h00000348);
		rd_chk("sleep gate clamp", 12'h110, 32'h00000248);
		wr_reg(12'h110, 32'h00000148);
		rd_chk("sleep gate", 12'h110, 32'h00000148);
		rd_chk("unmapped", 12'h004, 32'h0);
		core.set_sleep(1'b1);
		en_chk(5'h1e);
		core.set_sleep(1'b0);
		wr_reg(12'h060, 32'h00000001);
		core.set_sleep(1'b1);
		en_chk(5'h05);
		core.access(scg_pkg::SCG_UNIT_PWM, f, d);
		chk("gated pwm fault", 32'h1, {31'h0, f});
		core.access(scg_pkg::SCG_UNIT_WDT, f, d);
		chk("wdt done asleep", 32'h1, {31'h0, d});
		wr_reg(12'h110, 32'h00010000);
		en_chk(5'h08);
		core.set_sleep(1'b0);
		en_chk(5'h1e);
		@(posedge clock);
		ce <= 1'b0;
		wr_reg(12'h100, 32'h00000000);
		en_chk(5'h1e);
		@(posedge clock);
		ce <= 1'b1;
		rd_chk("run gate held", 12'h100, 32'h00110248);
		tally_and_finish;
	end
endmodule : scg_top_tb
